// ### design/sto_monitor.sv
`timescale 1ns/10ps
module sto_monitor #(
  parameter logic [30:0] MISMATCH_CYC = 31'(sto_pkg::MISMATCH_CYC_L)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire sto_pkg::sto_req_t req,
  input wire logic drive_alarm,
  output sto_pkg::sto_stat_t stat
);
  import sto_pkg::*;

  // ==========================================
  // per-path decode, one identical path per input
  logic [NUM_REQ-1:0] raw_low;
  logic [NUM_REQ-1:0] path_low_r;
  assign raw_low = {~req.torque_off_req_b, ~req.torque_off_req_a};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_path
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          path_low_r[gi] <= 1'b1; // fail safe: treat as stop until sampled
        end else begin
          path_low_r[gi] <= raw_low[gi];
        end
      end

      // each path checked on its own so one stuck input shows up alone
      path_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> path_low_r[gi] == $past(raw_low[gi]))
        else $error("stop request path did not follow its input");
    end
  endgenerate

  // ==========================================
  // state decision
  sto_state_t state_r;
  sto_state_t state_nxt;
  always_comb begin
    case (path_low_r)
      2'h3: state_nxt = STO_OFF;
      2'h0: state_nxt = STO_RUN;
      default: state_nxt = STO_STANDBY;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= STO_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  state_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $onehot(state_r))
    else $error("decision state is not one-hot");

  state_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (&path_low_r) |=> state_r == STO_OFF)
    else $error("both paths low did not select torque off");

  state_run_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (path_low_r == {NUM_REQ{1'b0}}) |=> state_r == STO_RUN)
    else $error("both paths high did not select run");

  state_standby_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (^path_low_r) |=> state_r == STO_STANDBY)
    else $error("one path low did not select standby");

  // ==========================================
  // mismatch timer, alarm latched until both inputs agree again
  logic [TMR_W-1:0] tmr_r;
  logic alarm_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_r <= TMR_ZERO;
    end else if (state_r == STO_STANDBY && tmr_r != MISMATCH_CYC) begin
      tmr_r <= tmr_r + TMR_ONE;
    end else if (state_r != STO_STANDBY) begin
      tmr_r <= TMR_ZERO;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_r <= 1'b0;
    end else if (state_r == STO_STANDBY && tmr_r == MISMATCH_CYC) begin
      alarm_r <= 1'b1;
    end else if (state_r != STO_STANDBY) begin
      alarm_r <= 1'b0;
    end
  end

  // timer saturates so a long mismatch cannot wrap and drop the alarm
  timer_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tmr_r <= MISMATCH_CYC)
    else $error("mismatch timer ran past its limit");

  timer_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == STO_STANDBY && tmr_r != MISMATCH_CYC) |=> tmr_r == $past(tmr_r) + TMR_ONE)
    else $error("mismatch timer did not advance in standby");

  timer_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r != STO_STANDBY) |=> tmr_r == TMR_ZERO)
    else $error("mismatch timer not cleared outside standby");

  alarm_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (alarm_r && state_r == STO_STANDBY) |=> alarm_r)
    else $error("mismatch alarm dropped while still in standby");

  alarm_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r != STO_STANDBY) |=> !alarm_r)
    else $error("mismatch alarm kept after inputs agreed");

  // ==========================================
  // outputs: standby keeps pwm running; only full request or alarm stops
  logic stop;
  assign stop = (state_r == STO_OFF) || drive_alarm;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat <= '{pwm_enable: 1'b0, gate_path_enable: 1'b0, safe_torque_disable: 1'b1,
                standby: 1'b0, mismatch_alarm: 1'b0};
    end else begin
      stat.pwm_enable <= ~stop;
      stat.gate_path_enable <= ~stop;
      stat.safe_torque_disable <= stop;
      stat.standby <= (state_r == STO_STANDBY);
      stat.mismatch_alarm <= alarm_r;
    end
  end

  // ==========================================
  // shutdown latency watch: cycles that pwm still runs after both
  // requests dropped; three pipeline stages, far below the limit
  logic [TMR_W-1:0] lat_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_r <= TMR_ZERO;
    end else if ((&raw_low) && stat.pwm_enable && lat_r != {TMR_W{1'b1}}) begin
      lat_r <= lat_r + TMR_ONE;
    end else if (!((&raw_low) && stat.pwm_enable)) begin
      lat_r <= TMR_ZERO;
    end
  end

  shutdown_time_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    longint'(lat_r) < SHUTDOWN_CYC_L)
    else $error("shutdown took longer than allowed");

  // ==========================================
  // checks on the outputs
  gate_pwm_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stat.pwm_enable == stat.gate_path_enable)
    else $error("gate path and pwm enables disagree");

  disable_inverse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stat.safe_torque_disable == !stat.pwm_enable)
    else $error("torque off flag not inverse of pwm enable");

  off_state_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == STO_OFF) |=> (stat.safe_torque_disable && !stat.gate_path_enable))
    else $error("torque off state did not isolate gates");

  run_state_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == STO_RUN && !drive_alarm) |=> (stat.pwm_enable && !stat.safe_torque_disable))
    else $error("run state did not allow pwm");

  standby_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == STO_STANDBY && !drive_alarm) |=> (stat.pwm_enable && stat.standby))
    else $error("standby state stopped pwm or hid standby");

  standby_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    1'b1 |=> stat.standby == ($past(state_r) == STO_STANDBY))
    else $error("standby flag does not follow state");

  alarm_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    1'b1 |=> stat.mismatch_alarm == $past(alarm_r))
    else $error("mismatch alarm output does not follow alarm");

  mismatch_no_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == STO_STANDBY && alarm_r && !drive_alarm) |=> stat.pwm_enable)
    else $error("mismatch alarm stopped pwm on its own");

  pwm_needs_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stat.pwm_enable |-> ($past(state_r) != STO_OFF && !$past(drive_alarm)))
    else $error("pwm enabled despite stop cause");

  no_false_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!drive_alarm && state_r != STO_OFF) |=> !stat.safe_torque_disable)
    else $error("torque off raised without a cause");

  alarm_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    drive_alarm |=> !stat.gate_path_enable)
    else $error("internal alarm left gate path enabled");

  // ==========================================
  // end to end checks from the pins; the alarm timing checks start from the mismatch timer
  both_low_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!req.torque_off_req_a && !req.torque_off_req_b) |-> ##3 (!stat.pwm_enable && !stat.gate_path_enable))
    else $error("torque not removed after both requests low");

  both_high_run_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.torque_off_req_a && req.torque_off_req_b && !drive_alarm)[*3] |=> stat.pwm_enable)
    else $error("pwm not enabled with both requests high");

  // three stage pipeline: standby shows one edge after the third sample
  one_low_standby_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.torque_off_req_a != req.torque_off_req_b)[*3] |=> stat.standby)
    else $error("standby not shown for mismatched requests");

  mismatch_alarm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == STO_STANDBY && tmr_r == MISMATCH_CYC) |-> ##2 stat.mismatch_alarm)
    else $error("mismatch alarm missing after timeout");

  no_early_alarm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(alarm_r) |-> $past(tmr_r) == MISMATCH_CYC)
    else $error("mismatch alarm raised early");

  alarm_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    drive_alarm |=> (stat.safe_torque_disable && !stat.pwm_enable))
    else $error("internal alarm did not stop torque");
endmodule

// ### include/sto_pkg.sv
// Overview of operation
// - both requests low: torque off, gates isolated
// - both requests high: normal pwm allowed
// - one request low: standby awaiting second
// - standby lasting five seconds raises alarm
// - shutdown completes well under ten milliseconds
// - internal alarm forces same shutdown always
// - two request paths handled separately, identically
package sto_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MISMATCH_S = 5;
  localparam int unsigned SHUTDOWN_MS = 10;
  localparam longint unsigned MISMATCH_CYC_L = longint'(MISMATCH_S) * 1000000 * CLK_MHZ;
  localparam longint unsigned SHUTDOWN_CYC_L = longint'(SHUTDOWN_MS) * 1000 * CLK_MHZ;
  localparam int TMR_W = 31;
  localparam int NUM_REQ = 2;
  localparam logic [TMR_W-1:0] TMR_ZERO = '0;
  localparam logic [TMR_W-1:0] TMR_ONE = {{(TMR_W-1){1'b0}}, 1'b1};

  // ==========================================
  // states
  typedef enum logic [2:0] {
    STO_RUN = 3'h1,
    STO_STANDBY = 3'h2,
    STO_OFF = 3'h4
  } sto_state_t;

  typedef struct packed {
    logic torque_off_req_a;
    logic torque_off_req_b;
  } sto_req_t;

  typedef struct packed {
    logic pwm_enable;
    logic gate_path_enable;
    logic safe_torque_disable;
    logic standby;
    logic mismatch_alarm;
  } sto_stat_t;
endpackage

// ### bench/sto_ctrl_model.sv
`timescale 1ns/10ps
module sto_ctrl_model (
  input wire logic ref_clk,
  input wire logic [1:0] want,
  output sto_pkg::sto_req_t req
);
  import sto_pkg::*;
  logic [1:0] w_l;
  initial req = 2'h3;
  // ==========
  // both paths move at the same edge
  always @(posedge ref_clk) begin
    w_l = want;
    #1 req = w_l;
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/10ps
module tb;
  import sto_pkg::*;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic drive_alarm = 0;
  logic [1:0] want = 2'h3;
  sto_req_t req;
  sto_stat_t stat;
  int error_cnt = 0;
  int check_count = 0;
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  sto_ctrl_model i_sto_ctrl_model(.ref_clk(ref_clk), .want(want), .req(req));
  sto_monitor #(.MISMATCH_CYC(31'h14)) i_sto_monitor(.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
    .drive_alarm(drive_alarm), .stat(stat));
  task chk(input logic [4:0] m, input logic [4:0] e);
    check_count++;
    if ((stat & m) !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, stat & m, e);
    end
  endtask
  task step(input logic [1:0] w, input int n);
    want = w;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task t_run;
    step(2'h3, 6);
    chk(5'h1F, 5'h18);
  endtask
  task t_off;
    step(2'h0, 6);
    chk(5'h1F, 5'h04);
  endtask
  // standby keeps pwm, alarm only after the timeout
  task t_half(input logic [1:0] w);
    step(w, 6);
    chk(5'h1F, 5'h1A);
    step(w, 24);
    chk(5'h1F, 5'h1B);
    t_run();
  endtask
  task t_alarm(input logic [1:0] w);
    step(w, 6);
    drive_alarm = 1;
    step(w, 3);
    chk(5'h1C, 5'h04);
    drive_alarm = 0;
    t_run();
  endtask
  initial begin
    #4000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    chk(5'h1F, 5'h04);
    rst_b = 1;
    t_run();
    t_off();
    t_run();
    t_half(2'h1);
    t_half(2'h2);
    t_alarm(2'h3);
    t_alarm(2'h1);
    conclude();
  end
endmodule
